// [pkg/pcs_pkg.sv]
// Package: constants and types for the peripheral cycle sequencer
package pcs_pkg;

  // ==========================================================================
  // Clock and timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int CLK_RATE_HZ = 20_000_000;
  // Minimum power-on reset pulse width on the reset line
  localparam int POR_PULSE_NS = 10_000;
  localparam int POR_PULSE_CYC = (POR_PULSE_NS * (CLK_RATE_HZ / 1_000_000) + 999) / 1000;

  // ==========================================================================
  // Cycle types and lengths, counted as extra clocks over a memory access
  typedef enum logic [1:0] {
    CYC_SLOW   = 2'h0,
    CYC_MEDIUM = 2'h1,
    CYC_FAST   = 2'h2,
    CYC_SYNC   = 2'h3
  } cycle_type_t;

  localparam logic [3:0] LEN_SLOW = 4'h7;
  localparam logic [3:0] LEN_MEDIUM = 4'h6;
  localparam logic [3:0] LEN_FAST = 4'h5;
  localparam logic [3:0] LEN_SYNC = 4'h5;
  // Strobe asserts after this many clocks of the cycle
  localparam logic [3:0] STROBE_START = 4'h1;
  // Strobe releases this many clocks before the end
  localparam logic [3:0] STROBE_TAIL = 4'h1;
  // Quarter-rate phase at which a synchronous cycle starts without waiting
  localparam logic [1:0] SYNC_PHASE = 2'h0;

  // ==========================================================================
  // Reset values
  localparam logic [5:0] CTRL_RESET = 6'h3f;
  localparam logic [6:0] SEL_IDLE = 7'h7f;
  localparam logic [1:0] QPH_RESET = 2'h0;

  // ==========================================================================
  // Bus request bundle from the memory controller side
  typedef struct packed {
    logic        req_n;
    logic        chip_sel;
    logic [2:0]  bank;
    logic        read_n_write;
    cycle_type_t ctype;
  } io_req_t;

  // Open-drain pin pair: output enable low while pulling low
  typedef struct packed {
    logic o;
    logic oe_n;
  } od_pin_t;

endpackage

// [design/pcs_reset_ctrl.sv]
// Reset combiner, power-on pulse stretcher and power-on interrupt latch
`timescale 1ns/10ps
`default_nettype none
module pcs_reset_ctrl
  import pcs_pkg::*;
#(
  parameter int POR_CYC = POR_PULSE_CYC
) (
  input  wire logic clk,            // System clock
  input  wire logic rst_n,          // Block reset, active low
  input  wire logic ext_rst_n,      // Reset line as sensed from the pin
  input  wire logic por_n,          // Power-on reset input
  input  wire logic irq_clear,      // Software clear of the power-on flag
  output logic      rst_drive_reg,  // Pull reset line low
  output logic      sys_rst_n_reg,  // Internal combined reset, active low
  output logic      por_irq_reg     // Latched power-on flag
);

  logic [15:0] por_cnt_reg;
  logic        por_seen_reg;

  // ==========================================================================
  // Stretch power-on into a minimum width pulse
  always_ff @(posedge clk) begin
    if (!por_n) begin
      por_cnt_reg <= 16'(POR_CYC);
    end else if (!rst_n) begin
      // Without this the counter is unknown until the first power-on
      por_cnt_reg <= 16'h0000;
    end else if (por_cnt_reg != 16'h0000) begin
      por_cnt_reg <= por_cnt_reg - 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    rst_drive_reg <= !por_n || (por_cnt_reg != 16'h0000);
  end

  // Either source resets the block
  always_ff @(posedge clk) begin
    sys_rst_n_reg <= ext_rst_n && por_n;
  end

  // ==========================================================================
  // Edge-latched power-on flag; a new power-on beats a clear
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      por_seen_reg <= 1'b0;
    end else begin
      por_seen_reg <= !por_n;
    end
  end

  always_ff @(posedge clk) begin
    if (!por_n && !por_seen_reg) begin
      por_irq_reg <= 1'b1;
    end else if (irq_clear || !rst_n) begin
      // Block reset clears it too; keep the power-on input low past it
      por_irq_reg <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// [design/pcs_sequencer.sv]
// Peripheral cycle sequencer: times slow external I/O cycles
`timescale 1ns/10ps
`default_nettype none
module pcs_sequencer
  import pcs_pkg::*;
#(
  parameter int POR_CYC = POR_PULSE_CYC
) (
  input  wire logic       CLK,                   // System clock, 20 MHz
  input  wire logic       RESETN,                // Synchronous reset, active low
  input  wire logic       IO_CYCLE_REQUEST_N,    // I/O cycle request
  input  wire logic       CHIP_SEL,              // Chip select
  input  wire logic [2:0] BANK_SELECT,           // Bank select
  input  wire logic       READ_N_WRITE,          // Bus direction, low = read
  input  wire logic [1:0] CYCLE_TYPE_SEL,        // Cycle type select
  input  wire logic       RST_IN,                // Reset line level sensed
  input  wire logic       POR_N,                 // Power-on reset input
  input  wire logic       POR_IRQ_CLEAR,         // Write one: clear power-on flag
  output logic            RST_O,                 // Reset line output value
  output logic            RST_OE_N,              // Reset line enable, low drives
  output logic            IO_CYCLE_GRANT_N_O,    // Grant output value
  output logic            IO_CYCLE_GRANT_N_OE_N, // Grant enable, low drives
  output logic            DATA_LATCH_CTRL_N_O,   // Latch control output value
  output logic            DATA_LATCH_CTRL_N_OE_N,// Latch control enable
  output logic            READ_BUFFER_ENABLE_N,  // Read buffer enable
  output logic            WRITE_BUFFER_ENABLE_N, // Write buffer enable
  output logic            PERIPH_READ_STROBE_N,  // Peripheral read strobe
  output logic            PERIPH_WRITE_STROBE_N, // Peripheral write strobe
  output logic [6:0]      PERIPH_SELECT_N,       // Peripheral selects 7..1
  output logic            QUARTER_CLK,           // Quarter-rate clock out
  output logic [5:0]      CONTROL_PORT_PINS,     // Control port pins
  output logic            POR_IRQ                // Latched power-on flag
);

  // ==========================================================================
  // Types and signals
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT,
    ST_RUN,
    ST_END
  } seq_state_t;

  io_req_t     req;
  seq_state_t  state_reg;
  logic [3:0]  cnt_reg;
  logic [3:0]  len_reg;
  logic        is_write_reg;
  logic        is_sync_reg;
  logic [2:0]  bank_reg;
  logic [1:0]  qph_reg;
  logic        rst_drive;
  logic        sys_rst_n;
  logic        por_irq;
  logic        reset_n;
  logic        decode_hit;
  logic        periph_start;
  logic        strobe_on;
  logic        strobe_end;
  logic [3:0]  len_sel;

  assign req = '{req_n: IO_CYCLE_REQUEST_N, chip_sel: CHIP_SEL, bank: BANK_SELECT,
                 read_n_write: READ_N_WRITE, ctype: cycle_type_t'(CYCLE_TYPE_SEL)};

  // ==========================================================================
  // Reset sources
  pcs_reset_ctrl #(
    .POR_CYC (POR_CYC)
  ) u_reset (
    .clk           (CLK),
    .rst_n         (RESETN),
    .ext_rst_n     (RST_IN),
    .por_n         (POR_N),
    .irq_clear     (POR_IRQ_CLEAR),
    .rst_drive_reg (rst_drive),
    .sys_rst_n_reg (sys_rst_n),
    .por_irq_reg   (por_irq)
  );

  assign reset_n = RESETN && sys_rst_n;

  // ==========================================================================
  // Decode; bank 0 is internal registers, others are peripherals
  // Grant may not wait for the request, which comes too late
  // for a two-clock internal access
  assign decode_hit = req.chip_sel && (req.bank == 3'h0);
  assign periph_start = req.chip_sel && !req.req_n && (req.bank != 3'h0);

  always_comb begin
    case (req.ctype)
      CYC_SLOW:   len_sel = LEN_SLOW;
      CYC_MEDIUM: len_sel = LEN_MEDIUM;
      CYC_FAST:   len_sel = LEN_FAST;
      CYC_SYNC:   len_sel = LEN_SYNC;
      default:    len_sel = LEN_SYNC;
    endcase
  end

  // ==========================================================================
  // Quarter-rate clock, the reference for synchronous cycles
  always_ff @(posedge CLK) begin
    if (!reset_n) begin
      qph_reg <= QPH_RESET;
    end else begin
      qph_reg <= qph_reg + 2'h1;
    end
  end

  // ==========================================================================
  // Cycle state machine
  // Requests outside IDLE are dropped; the host must not overlap cycles
  always_ff @(posedge CLK) begin
    if (!reset_n) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (periph_start) begin
            // Sync type waits for the optimal phase
            if (req.ctype == CYC_SYNC && qph_reg != SYNC_PHASE) begin
              state_reg <= ST_WAIT;
            end else begin
              state_reg <= ST_RUN;
            end
          end
        end
        ST_WAIT: begin
          if (qph_reg == SYNC_PHASE) begin
            state_reg <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (cnt_reg == len_reg - 4'h1) begin
            state_reg <= ST_END;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Captured at the request so the cycle keeps a fixed length
  always_ff @(posedge CLK) begin
    if (!reset_n) begin
      len_reg <= LEN_SLOW;
      is_write_reg <= 1'b0;
      is_sync_reg <= 1'b0;
      bank_reg <= 3'h0;
    end else if (state_reg == ST_IDLE && periph_start) begin
      len_reg <= len_sel;
      is_write_reg <= req.read_n_write;
      is_sync_reg <= (req.ctype == CYC_SYNC);
      bank_reg <= req.bank;
    end
  end

  // Counts extra clocks of the run phase only
  always_ff @(posedge CLK) begin
    if (!reset_n || state_reg != ST_RUN) begin
      cnt_reg <= 4'h0;
    end else begin
      cnt_reg <= cnt_reg + 4'h1;
    end
  end

  // ==========================================================================
  // Strobe timing
  // Fixed types: one pulse inside the cycle; sync type: low half of CLK/4
  always_comb begin
    if (state_reg != ST_RUN) begin
      strobe_on = 1'b0;
    end else if (is_sync_reg) begin
      strobe_on = (qph_reg[1] == 1'b0);
    end else begin
      strobe_on = (cnt_reg >= STROBE_START) && (cnt_reg < len_reg - STROBE_TAIL);
    end
  end

  assign strobe_end = !PERIPH_READ_STROBE_N && !strobe_on;

  always_ff @(posedge CLK) begin
    if (!reset_n) begin
      PERIPH_READ_STROBE_N <= 1'b1;
      PERIPH_WRITE_STROBE_N <= 1'b1;
    end else begin
      PERIPH_READ_STROBE_N <= !(strobe_on && !is_write_reg);
      PERIPH_WRITE_STROBE_N <= !(strobe_on && is_write_reg);
    end
  end

  // ==========================================================================
  // Selects; address and data paths are external
  always_ff @(posedge CLK) begin
    if (!reset_n) begin
      PERIPH_SELECT_N <= SEL_IDLE;
    end else if (state_reg == ST_IDLE && periph_start) begin
      PERIPH_SELECT_N <= ~(7'h01 << (req.bank - 3'h1));
    end else if (state_reg == ST_END) begin
      PERIPH_SELECT_N <= SEL_IDLE;
    end
  end

  // ==========================================================================
  // Open-drain grant and latch control; value pins stay low
  always_ff @(posedge CLK) begin
    if (!reset_n) begin
      IO_CYCLE_GRANT_N_O <= 1'b0;
      IO_CYCLE_GRANT_N_OE_N <= 1'b1;
    end else if (state_reg != ST_IDLE && state_reg != ST_END) begin
      // Value stays low; only the enable moves, so the pin never drives high
      IO_CYCLE_GRANT_N_OE_N <= 1'b0;
      IO_CYCLE_GRANT_N_O <= 1'b0;
    end else begin
      // Decode-only, so it may also pull during non-I/O cycles
      IO_CYCLE_GRANT_N_OE_N <= !decode_hit;
      IO_CYCLE_GRANT_N_O <= 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (!reset_n) begin
      DATA_LATCH_CTRL_N_O <= 1'b0;
      DATA_LATCH_CTRL_N_OE_N <= 1'b1;
    end else if (state_reg == ST_IDLE && periph_start && req.read_n_write) begin
      DATA_LATCH_CTRL_N_OE_N <= 1'b0;
    // Read data held from the strobe's rising edge to the cycle end
    end else if (state_reg == ST_RUN && !is_write_reg && strobe_end) begin
      DATA_LATCH_CTRL_N_OE_N <= 1'b0;
    end else if (state_reg == ST_END) begin
      DATA_LATCH_CTRL_N_OE_N <= 1'b1;
    end
  end

  // ==========================================================================
  // Buffer enables follow the bus whether or not this device is selected
  always_ff @(posedge CLK) begin
    if (!reset_n) begin
      READ_BUFFER_ENABLE_N <= 1'b1;
      WRITE_BUFFER_ENABLE_N <= 1'b1;
    end else begin
      READ_BUFFER_ENABLE_N <= req.req_n || req.read_n_write;
      WRITE_BUFFER_ENABLE_N <= !req.read_n_write;
    end
  end

  // ==========================================================================
  // Misc outputs
  always_ff @(posedge CLK) begin
    if (!reset_n) begin
      CONTROL_PORT_PINS <= CTRL_RESET;
    end else begin
      CONTROL_PORT_PINS <= CONTROL_PORT_PINS;
    end
  end

  // Sync strobes line up with this copy of the phase counter
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      QUARTER_CLK <= 1'b0;
    end else begin
      QUARTER_CLK <= qph_reg[1];
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      RST_O <= 1'b0;
      RST_OE_N <= 1'b1;
      POR_IRQ <= 1'b0;
    end else begin
      RST_O <= 1'b0;
      RST_OE_N <= !rst_drive;
      POR_IRQ <= por_irq;
    end
  end

endmodule
`default_nettype wire

// [testbench/pcs_sequencer_props.sv]
// Concurrent checks on the peripheral cycle sequencer ports
`timescale 1ns/10ps
`default_nettype none
module pcs_sequencer_props
  import pcs_pkg::*;
#(
  parameter int POR_CYC = POR_PULSE_CYC
) (
  input wire logic       CLK,                    // Clock
  input wire logic       RESETN,                 // Reset
  input wire logic       IO_CYCLE_REQUEST_N,     // Request
  input wire logic       CHIP_SEL,               // Chip select
  input wire logic [2:0] BANK_SELECT,            // Bank
  input wire logic       READ_N_WRITE,           // Direction
  input wire logic       RST_IN,                 // Reset line
  input wire logic       POR_N,                  // Power-on input
  input wire logic       RST_OE_N,               // Reset drive
  input wire logic       IO_CYCLE_GRANT_N_O,     // Grant value
  input wire logic       IO_CYCLE_GRANT_N_OE_N,  // Grant enable
  input wire logic       DATA_LATCH_CTRL_N_O,    // Latch value
  input wire logic       DATA_LATCH_CTRL_N_OE_N, // Latch enable
  input wire logic       PERIPH_READ_STROBE_N,   // Read strobe
  input wire logic       PERIPH_WRITE_STROBE_N,  // Write strobe
  input wire logic [6:0] PERIPH_SELECT_N,        // Selects
  input wire logic [5:0] CONTROL_PORT_PINS,      // Control pins
  input wire logic       POR_IRQ                 // Power-on flag
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESETN);
  // ==========================================================================
  // Reset
  chk_rst_idle: assert property (
    $rose(RESETN) |-> PERIPH_SELECT_N == SEL_IDLE && CONTROL_PORT_PINS == CTRL_RESET
      && PERIPH_READ_STROBE_N && PERIPH_WRITE_STROBE_N && IO_CYCLE_GRANT_N_OE_N)
    else $error("outputs not idle after reset");
  chk_por_pulse: assert property (
    $rose(POR_N) |-> !RST_OE_N [*3]) else $error("reset pulse too short");
  chk_irq_set: assert property (
    $fell(POR_N) |-> ##[1:3] POR_IRQ) else $error("power-on flag not set");
  // ==========================================================================
  // Cycle control
  chk_one_strobe: assert property (
    !(!PERIPH_READ_STROBE_N && !PERIPH_WRITE_STROBE_N)) else $error("both strobes low");
  chk_od_pins: assert property (
    (!IO_CYCLE_GRANT_N_OE_N |-> !IO_CYCLE_GRANT_N_O) and (!DATA_LATCH_CTRL_N_OE_N |-> !DATA_LATCH_CTRL_N_O))
    else $error("open-drain pin drives high");
  chk_strobe_sel: assert property (
    !PERIPH_READ_STROBE_N || !PERIPH_WRITE_STROBE_N |-> PERIPH_SELECT_N != SEL_IDLE)
    else $error("strobe without select");
  chk_sel_cause: assert property (
    $fell(PERIPH_SELECT_N == SEL_IDLE) |-> $past(!IO_CYCLE_REQUEST_N && CHIP_SEL)
      && PERIPH_SELECT_N == ~(7'h01 << ($past(BANK_SELECT) - 3'h1)))
    else $error("select without matching request");
  chk_bank_zero: assert property (
    CHIP_SEL && !IO_CYCLE_REQUEST_N && BANK_SELECT == 3'h0 && PERIPH_SELECT_N == SEL_IDLE
      |=> PERIPH_SELECT_N == SEL_IDLE) else $error("internal access started a cycle");
  chk_grant_dec: assert property (
    CHIP_SEL && BANK_SELECT == 3'h0 && RST_IN && POR_N && PERIPH_SELECT_N == SEL_IDLE
      |=> !IO_CYCLE_GRANT_N_OE_N) else $error("grant not decoded");
  chk_write_latch: assert property (
    $fell(PERIPH_SELECT_N == SEL_IDLE) && $past(READ_N_WRITE) |-> !DATA_LATCH_CTRL_N_OE_N)
    else $error("write latch not low at start");
  chk_read_latch: assert property (
    $rose(PERIPH_READ_STROBE_N) && PERIPH_SELECT_N != SEL_IDLE |-> ##[0:1] !DATA_LATCH_CTRL_N_OE_N)
    else $error("read latch not low after strobe");
endmodule
`default_nettype wire

// [testbench/pcs_periph_model.sv]
// Far-side model: pulled-up open-drain wires and an outside reset source
`timescale 1ns/10ps
`default_nettype none
module pcs_periph_model (
  input  wire logic rst_o,    // Device reset value
  input  wire logic rst_oe_n, // Device reset enable
  input  wire logic gnt_o,    // Device grant value
  input  wire logic gnt_oe_n, // Device grant enable
  input  wire logic lat_o,    // Device latch value
  input  wire logic lat_oe_n, // Device latch enable
  input  wire logic ext_pull, // Outside logic pulls reset low
  output logic      rst_line, // Resolved reset wire
  output logic      gnt_line, // Resolved grant wire
  output logic      lat_line  // Resolved latch wire
);
  // Pull-ups: a released wire reads high, never the last value
  assign rst_line = (rst_oe_n | rst_o) & ~ext_pull;
  assign gnt_line = gnt_oe_n | gnt_o;
  assign lat_line = lat_oe_n | lat_o;
endmodule
`default_nettype wire

// [testbench/test_peripheral_cycle_sequencer.sv]
// Self-checking bench for the peripheral cycle sequencer
`timescale 1ns/10ps
`default_nettype none
module test_peripheral_cycle_sequencer;
  import pcs_pkg::*;
  localparam int POR_SIM = 4;
  logic       clk = 1'b0;
  logic       resetn = 1'b0;
  logic       req_n = 1'b1;
  logic       cs = 1'b0;
  logic [2:0] bank = 3'h0;
  logic       rw = 1'b0;
  logic [1:0] ctype = 2'h0;
  logic       por_n = 1'b1;
  logic       irq_clr = 1'b0;
  logic       ext_pull = 1'b0;
  logic       rst_o, rst_oe_n, gnt_o, gnt_oe_n, lat_o, lat_oe_n, rbe_n, wbe_n, rd_n, wr_n, qclk, irq;
  logic       rst_line, gnt_line, lat_line;
  logic [6:0] sel_n;
  logic [5:0] ctrl;
  int         errors = 0;
  int         cmp_count = 0;
  int         n_sel, n_gnt, n_rd, n_wr, n_lat, n_lock;

  always #25 clk = ~clk;

  pcs_sequencer #(.POR_CYC(POR_SIM)) u_dut (.CLK(clk), .RESETN(resetn), .IO_CYCLE_REQUEST_N(req_n), .CHIP_SEL(cs),
    .BANK_SELECT(bank), .READ_N_WRITE(rw), .CYCLE_TYPE_SEL(ctype), .RST_IN(rst_line), .POR_N(por_n),
    .POR_IRQ_CLEAR(irq_clr), .RST_O(rst_o), .RST_OE_N(rst_oe_n), .IO_CYCLE_GRANT_N_O(gnt_o),
    .IO_CYCLE_GRANT_N_OE_N(gnt_oe_n), .DATA_LATCH_CTRL_N_O(lat_o), .DATA_LATCH_CTRL_N_OE_N(lat_oe_n),
    .READ_BUFFER_ENABLE_N(rbe_n), .WRITE_BUFFER_ENABLE_N(wbe_n), .PERIPH_READ_STROBE_N(rd_n),
    .PERIPH_WRITE_STROBE_N(wr_n), .PERIPH_SELECT_N(sel_n), .QUARTER_CLK(qclk), .CONTROL_PORT_PINS(ctrl),
    .POR_IRQ(irq));

  pcs_periph_model u_far (.rst_o(rst_o), .rst_oe_n(rst_oe_n), .gnt_o(gnt_o), .gnt_oe_n(gnt_oe_n), .lat_o(lat_o),
    .lat_oe_n(lat_oe_n), .ext_pull(ext_pull), .rst_line(rst_line), .gnt_line(gnt_line), .lat_line(lat_line));

  function automatic int exp_len(input logic [1:0] t);
    case (t)
      2'h0: return LEN_SLOW;
      2'h1: return LEN_MEDIUM;
      2'h2: return LEN_FAST;
      default: return LEN_SYNC;
    endcase
  endfunction

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // One peripheral cycle; counts output lows per clock until selects release
  task automatic run_cycle(input logic [2:0] b, input logic w, input logic [1:0] t);
    int         len;
    bit         done;
    logic [6:0] exp_sel;
    len = exp_len(t);
    done = 0;
    exp_sel = ~(7'h01 << (b - 3'h1));
    {n_sel, n_gnt, n_rd, n_wr, n_lat, n_lock} = '0;
    req_n = 1'b0;
    cs = 1'b1;
    bank = b;
    rw = w;
    ctype = t;
    @(negedge clk);
    req_n = 1'b1;
    cs = 1'b0;
    check("select_bit", sel_n, exp_sel);
    check("buf_en", {rbe_n, wbe_n}, {w, ~w});
    for (int i = 0; i < 40 && !done; i++) begin
      n_sel += int'(sel_n !== SEL_IDLE);
      n_gnt += int'(gnt_line === 1'b0);
      n_rd += int'(rd_n === 1'b0);
      n_wr += int'(wr_n === 1'b0);
      n_lat += int'(lat_line === 1'b0);
      n_lock += int'(!(w ? wr_n : rd_n) && qclk !== 1'b0);
      @(negedge clk);
      done = (sel_n === SEL_IDLE);
    end
    check("finished", done, 1'b1);
    if (!done) test_done();
    if (t != CYC_SYNC) check("sel_len", n_sel, len + 1);
    else check("sync_len", n_sel >= len + 1 && n_sel <= len + 4, 1'b1);
    check("grant_len", n_gnt, n_sel - 1);
    check("other_strobe", w ? n_rd : n_wr, 0);
    if (t != CYC_SYNC) check("strobe_len", w ? n_wr : n_rd, len - 2);
    else check("sync_strobe", (w ? n_wr : n_rd) > 0, 1'b1);
    if (t == CYC_SYNC) check("sync_lock", n_lock, 0);
    if (w) check("wr_latch", n_lat, n_sel);
    else check("rd_latch", n_lat > 0 && n_lat < n_gnt, 1'b1);
  endtask

  initial begin
    void'($urandom(33));
    repeat (5) @(negedge clk);
    resetn = 1'b1;
    repeat (2) @(negedge clk);
    check("ctrl_reset", ctrl, CTRL_RESET);
    check("sel_idle", sel_n, SEL_IDLE);
    check("strobes_idle", {rd_n, wr_n, gnt_line, lat_line}, 4'hf);
    check("bufen_driven", {rbe_n, wbe_n}, 2'b11);
    n_sel = 0;
    repeat (4) begin
      n_sel += int'(qclk === 1'b1);
      @(negedge clk);
    end
    check("qclk_duty", n_sel, 2);
    // Every type both ways at the outer banks, then random traffic with 0 to 3 idle clocks before each cycle
    for (int t = 0; t < 4; t++) begin
      run_cycle(3'h1, 1'b0, 2'(t));
      run_cycle(3'h7, 1'b1, 2'(t));
    end
    for (int k = 0; k < 30; k++) begin
      repeat ($urandom_range(3)) @(negedge clk);
      run_cycle(3'($urandom_range(7, 1)), 1'($urandom()), 2'($urandom()));
    end
    cs = 1'b1;
    req_n = 1'b0;
    bank = 3'h0;
    @(negedge clk);
    check("int_no_sel", sel_n, SEL_IDLE);
    check("int_grant", gnt_line, 1'b0);
    req_n = 1'b1;
    @(negedge clk);
    check("dec_grant", {sel_n, gnt_line}, {SEL_IDLE, 1'b0});
    bank = 3'h5;
    @(negedge clk);
    check("periph_no_grant", gnt_line, 1'b1);
    cs = 1'b0;
    @(negedge clk);
    // Abort a slow write by block reset, then by an outside pull on the reset line
    for (int s = 0; s < 2; s++) begin
      req_n = 1'b0;
      cs = 1'b1;
      bank = 3'h3;
      ctype = CYC_SLOW;
      rw = 1'b1;
      @(negedge clk);
      req_n = 1'b1;
      cs = 1'b0;
      repeat (3) @(negedge clk);
      if (s == 0) resetn = 1'b0;
      else ext_pull = 1'b1;
      @(negedge clk);
      resetn = 1'b1;
      ext_pull = 1'b0;
      repeat (2) @(negedge clk);
      check("abort_idle", {ctrl, sel_n, wr_n, lat_line, gnt_line}, {CTRL_RESET, SEL_IDLE, 3'h7});
    end
    por_n = 1'b0;
    repeat (3) @(negedge clk);
    por_n = 1'b1;
    n_sel = 0;
    for (int i = 0; i < 50 && rst_line === 1'b0; i++) begin
      n_sel++;
      @(negedge clk);
    end
    check("por_pulse", n_sel >= POR_SIM && n_sel < 50, 1'b1);
    check("por_flag", irq, 1'b1);
    repeat (5) @(negedge clk);
    check("flag_kept", irq, 1'b1);
    irq_clr = 1'b1;
    @(negedge clk);
    irq_clr = 1'b0;
    repeat (2) @(negedge clk);
    check("flag_clear", irq, 1'b0);
    run_cycle(3'h2, 1'b0, CYC_FAST);
    test_done();
  end
endmodule

bind pcs_sequencer pcs_sequencer_props #(.POR_CYC(POR_CYC)) u_props (.CLK(CLK), .RESETN(RESETN),
  .IO_CYCLE_REQUEST_N(IO_CYCLE_REQUEST_N), .CHIP_SEL(CHIP_SEL), .BANK_SELECT(BANK_SELECT),
  .READ_N_WRITE(READ_N_WRITE), .RST_IN(RST_IN), .POR_N(POR_N), .RST_OE_N(RST_OE_N),
  .IO_CYCLE_GRANT_N_O(IO_CYCLE_GRANT_N_O), .IO_CYCLE_GRANT_N_OE_N(IO_CYCLE_GRANT_N_OE_N),
  .DATA_LATCH_CTRL_N_O(DATA_LATCH_CTRL_N_O), .DATA_LATCH_CTRL_N_OE_N(DATA_LATCH_CTRL_N_OE_N),
  .PERIPH_READ_STROBE_N(PERIPH_READ_STROBE_N), .PERIPH_WRITE_STROBE_N(PERIPH_WRITE_STROBE_N),
  .PERIPH_SELECT_N(PERIPH_SELECT_N), .CONTROL_PORT_PINS(CONTROL_PORT_PINS), .POR_IRQ(POR_IRQ));
`default_nettype wire
